// file: scli_board.sv
`timescale 1ns/100ps
`default_nettype none
module scli_board
(
  // resistor level per pin, {three, two, one, zero}
  input wire logic [11:0] strap_in,
  // device pin halves
  input wire logic [11:0] drv_in,
  input wire logic [2:0] oe_b_in,
  // resolved pin levels
  output logic [11:0] lvl_out
);
  // a released pin falls to its resistor, never keeps the lamp level
  always_comb
  begin
    for (int g = 0; g < 4; g++)
      for (int p = 0; p < 3; p++)
        lvl_out[g*3+p] = oe_b_in[p] ? strap_in[g*3+p] : drv_in[g*3+p];
  end
endmodule
`default_nettype wire

// file: scli_defines.svh
// Overview of operation
// - mode straps caught at reset, then frozen
// - mode code picks LED mode, frame limit
// - indicator zero shows speed or receive collision
// - indicator one shows duplex except mode 3
// - indicator two: collision mode 0, transmit mode 1
// - indicator two: 10M link mode 2, duplex or collision mode 3
// - indicator three shows link and activity, receive in mode 1
// - low pause strap forces port 1/2 pause
// - port 1 indicator three strap advertises pause
// - port 1 indicator two strap forces port 3 pause
// - port 2 indicator three strap enables aging
// - port 3 indicator straps force 100M or 10M
// - high autoneg strap disables port 3 negotiation
// - two-bit strap selects external port mode
// - external collision input used in forward mode only
`ifndef SCLI_DEFINES_SVH
`define SCLI_DEFINES_SVH

// register byte offsets
`define SCLI_ADDR_CONFIG 4'h0
`define SCLI_ADDR_CTRL 4'h4
`define SCLI_ADDR_STATUS 4'h8
`define SCLI_CTRL_RST 1'b1

// mode select codes
`define SCLI_CODE_M0 4'h0
`define SCLI_CODE_M1 4'h1
`define SCLI_CODE_M2 4'h2
`define SCLI_CODE_M3 4'h3
`define SCLI_CODE_LONG_M3 4'hb
`define SCLI_CODE_LONG_M0 4'hc
`define SCLI_CODE_LONG_M2 4'he

// frame length limits in bytes
`define SCLI_LEN_UNTAG 11'h5ee
`define SCLI_LEN_TAG 11'h5f2
`define SCLI_LEN_LONG 11'h600

// blink timing
`define SCLI_CLK_KHZ 100000
`define SCLI_BLINK_MS 50
`define SCLI_BLINK_CYCLES (`SCLI_BLINK_MS * `SCLI_CLK_KHZ)

`endif

// file: scli_pkg.sv
package scli_pkg;

  // external port modes, in strap encoding order
  typedef enum logic [1:0] {
    SCLI_EXT_OFF,
    SCLI_EXT_REVERSE,
    SCLI_EXT_FORWARD,
    SCLI_EXT_SERIAL
  } scli_ext_mode_t;

  // per-port event stretchers
  typedef struct packed {
    logic rx_s;
    logic tx_s;
    logic col_s;
  } scli_port_st_t;

endpackage

// file: scli_port_if.sv
`timescale 1ns/100ps
`default_nettype none
interface scli_port_if;
  logic link;
  logic spd100;
  logic fdx;
  logic rx;
  logic tx;
  logic col;
  logic [1:0] mode;
  logic blink;
  logic tick;
  logic [3:0] leds;
  modport core (output link, spd100, fdx, rx, tx, col, mode, blink, tick,
    input leds);
  modport port (input link, spd100, fdx, rx, tx, col, mode, blink, tick,
    output leds);
endinterface
`default_nettype wire

// file: scli_port_led.sv
`timescale 1ns/100ps
`default_nettype none
module scli_port_led
  import scli_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // port status and indicator levels
  scli_port_if.port bus
);

  scli_port_st_t s_r;
  scli_port_st_t s_nxt;
  logic rx_act;
  logic tx_act;
  logic col_act;
  logic any_act;

  // stretch events over one blink period; a new event beats the clear
  always_comb
  begin
    s_nxt = s_r;
    if (bus.tick)
    begin
      s_nxt = '0;
    end
    if (bus.rx)
    begin
      s_nxt.rx_s = 1'b1;
    end
    if (bus.tx)
    begin
      s_nxt.tx_s = 1'b1;
    end
    if (bus.col && bus.rx)
    begin
      s_nxt.col_s = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // a blinking lamp alternates with the shared phase
  assign rx_act = (s_r.rx_s | bus.rx) & bus.blink;
  assign tx_act = (s_r.tx_s | bus.tx) & bus.blink;
  assign col_act = (s_r.col_s | (bus.col & bus.rx)) & bus.blink;
  assign any_act = (s_r.rx_s | s_r.tx_s | bus.rx | bus.tx) & bus.blink;

  // indicator levels, low means lit
  always_comb
  begin
    bus.leds = 4'hf;
    unique case (bus.mode)
      2'h0:
      begin
        bus.leds[0] = ~bus.spd100;
        bus.leds[1] = ~bus.fdx;
        bus.leds[2] = ~col_act;
        bus.leds[3] = bus.link ? any_act : 1'b1;
      end
      2'h1:
      begin
        bus.leds[1] = ~bus.fdx;
        bus.leds[2] = ~tx_act;
        bus.leds[3] = ~rx_act;
      end
      2'h2:
      begin
        bus.leds[0] = ~col_act;
        bus.leds[1] = ~bus.fdx;
        // 10 Mbit link lamp on two, 100 Mbit link lamp on three
        bus.leds[2] = (bus.link && !bus.spd100) ? any_act : 1'b1;
        bus.leds[3] = (bus.link && bus.spd100) ? any_act : 1'b1;
      end
      2'h3:
      begin
        bus.leds[0] = ~bus.spd100;
        bus.leds[2] = (bus.link && bus.fdx) ? 1'b0 : ~col_act;
        bus.leds[3] = bus.link ? any_act : 1'b1;
      end
    endcase
  end

endmodule
`default_nettype wire

// file: scli_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "scli_defines.svh"
module scli_top
  import scli_pkg::*;
#(
  parameter int BLINK_CYCLES = `SCLI_BLINK_CYCLES
)
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // dedicated strap pins
  input wire logic [3:0] indicator_mode_select_in,
  input wire logic force_pause_p1_n_in,
  input wire logic force_pause_p2_n_in,
  input wire logic p3_autoneg_off_in,
  input wire logic [1:0] ext_port_mode_sel_in,
  // indicator pins, bit 0 is port 1
  input wire logic [2:0] port_indicator_zero_in,
  input wire logic [2:0] port_indicator_one_in,
  input wire logic [2:0] port_indicator_two_in,
  input wire logic [2:0] port_indicator_three_in,
  output logic [2:0] port_indicator_zero_out,
  output logic [2:0] port_indicator_one_out,
  output logic [2:0] port_indicator_two_out,
  output logic [2:0] port_indicator_three_out,
  output logic [2:0] port_indicator_oe_b_out,
  // live port status from the phys
  input wire logic [2:0] link_up_in,
  input wire logic [2:0] speed100_in,
  input wire logic [2:0] full_duplex_in,
  input wire logic [2:0] rx_active_in,
  input wire logic [2:0] tx_active_in,
  input wire logic [2:0] collision_in,
  // external port collision
  input wire logic ext_collision_in,
  output logic ext_collision_fwd_out,
  // captured configuration
  output logic [1:0] led_mode_out,
  output logic factory_test_out,
  output logic [10:0] max_len_untag_out,
  output logic [10:0] max_len_tag_out,
  output logic [2:0] force_pause_out,
  output logic advertise_pause_out,
  output logic aging_on_out,
  output logic [2:0] force_speed100_out,
  output logic p3_autoneg_off_out,
  output scli_ext_mode_t ext_port_mode_out
);

  localparam int CW = $clog2(BLINK_CYCLES + 1);

  typedef struct packed {
    logic captured;
    logic [3:0] code;
    logic [1:0] led_mode;
    logic long_frames;
    logic [10:0] len_untag;
    logic [10:0] len_tag;
    logic factory_test;
    logic [2:0] force_pause;
    logic advertise;
    logic aging;
    logic [2:0] fspd;
    logic an3_off;
    scli_ext_mode_t ext_mode;
    logic col_fwd;
    logic ind_en;
    logic [CW-1:0] blink_cnt;
    logic blink;
    logic tick;
    logic [2:0] led0;
    logic [2:0] led1;
    logic [2:0] led2;
    logic [2:0] led3;
    logic [2:0] oe_b;
    logic ack;
    logic [31:0] rdata;
  } scli_top_st_t;

  localparam scli_top_st_t ST_RST = '{
    led0: 3'h7,
    led1: 3'h7,
    led2: 3'h7,
    led3: 3'h7,
    oe_b: 3'h7,
    len_untag: `SCLI_LEN_UNTAG,
    len_tag: `SCLI_LEN_TAG,
    ind_en: `SCLI_CTRL_RST,
    ext_mode: SCLI_EXT_OFF,
    default: '0
  };

  scli_top_st_t s_r;
  scli_top_st_t s_nxt;
  logic [3:0] port_leds [3];
  logic wb_req;
  logic ind_on;

  scli_port_if pif [3] ();

  // one indicator decoder per port
  for (genvar g = 0; g < 3; g++)
  begin : g_port
    assign pif[g].link = link_up_in[g];
    assign pif[g].spd100 = speed100_in[g];
    assign pif[g].fdx = full_duplex_in[g];
    assign pif[g].rx = rx_active_in[g];
    assign pif[g].tx = tx_active_in[g];
    assign pif[g].col = collision_in[g];
    assign pif[g].mode = s_r.led_mode;
    assign pif[g].blink = s_r.blink;
    assign pif[g].tick = s_r.tick;
    assign port_leds[g] = pif[g].leds;
    scli_port_led u_led (
      .clock_in(clock_in),
      .rst_b_in(rst_b_in),
      .bus(pif[g])
    );
  end

  assign wb_req = wb_cyc_in & wb_stb_in & ~s_r.ack;
  assign ind_on = s_r.captured & s_r.ind_en;

  // next state: capture, blink, indicators, bus
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    // blink phase generator
    if (s_r.blink_cnt == CW'(BLINK_CYCLES - 1))
    begin
      s_nxt.blink_cnt = '0;
      s_nxt.blink = ~s_r.blink;
      s_nxt.tick = s_r.blink;
    end
    else
    begin
      s_nxt.blink_cnt = s_r.blink_cnt + CW'(1);
    end
    // straps are taken once, on the first edge after release
    if (!s_r.captured)
    begin
      s_nxt.captured = 1'b1;
      s_nxt.code = indicator_mode_select_in;
      s_nxt.long_frames = 1'b0;
      s_nxt.factory_test = 1'b0;
      s_nxt.led_mode = 2'h0;
      // every usable code carries its led mode in the low two bits
      unique case (indicator_mode_select_in)
        `SCLI_CODE_M0, `SCLI_CODE_M1, `SCLI_CODE_M2, `SCLI_CODE_M3:
        begin
          s_nxt.led_mode = indicator_mode_select_in[1:0];
        end
        `SCLI_CODE_LONG_M3, `SCLI_CODE_LONG_M0, `SCLI_CODE_LONG_M2:
        begin
          s_nxt.led_mode = indicator_mode_select_in[1:0];
          s_nxt.long_frames = 1'b1;
        end
        default:
        begin
          s_nxt.factory_test = 1'b1;
        end
      endcase
      // limits held in flops so the outputs come straight off them
      s_nxt.len_untag = s_nxt.long_frames ? `SCLI_LEN_LONG : `SCLI_LEN_UNTAG;
      s_nxt.len_tag = s_nxt.long_frames ? `SCLI_LEN_LONG : `SCLI_LEN_TAG;
      s_nxt.force_pause[0] = ~force_pause_p1_n_in;
      s_nxt.force_pause[1] = ~force_pause_p2_n_in;
      s_nxt.force_pause[2] = port_indicator_two_in[0];
      s_nxt.advertise = port_indicator_three_in[0];
      s_nxt.aging = port_indicator_three_in[1];
      s_nxt.fspd = {port_indicator_two_in[2], port_indicator_one_in[2],
        port_indicator_zero_in[2]};
      s_nxt.an3_off = p3_autoneg_off_in;
      s_nxt.ext_mode = scli_ext_mode_t'(ext_port_mode_sel_in);
    end
    // pins start driving only once the straps are held
    s_nxt.oe_b = s_r.captured ? 3'h0 : 3'h7;
    // indicators stay dark until the decoders see the captured mode
    for (int p = 0; p < 3; p++)
    begin
      s_nxt.led0[p] = port_leds[p][0] | ~ind_on;
      s_nxt.led1[p] = port_leds[p][1] | ~ind_on;
      s_nxt.led2[p] = port_leds[p][2] | ~ind_on;
      s_nxt.led3[p] = port_leds[p][3] | ~ind_on;
    end
    // other party's collision only matters in forward mode
    s_nxt.col_fwd = (s_r.ext_mode == SCLI_EXT_FORWARD) &&
      ext_collision_in;
    // single-wait wishbone slave; unmapped reads return zero
    s_nxt.ack = wb_req;
    if (wb_req)
    begin
      unique case (wb_adr_in)
        `SCLI_ADDR_CONFIG:
        begin
          s_nxt.rdata = 32'({s_r.code, s_r.ext_mode, s_r.an3_off, s_r.fspd,
            s_r.aging, s_r.advertise, s_r.force_pause, s_r.long_frames,
            s_r.factory_test, s_r.led_mode});
        end
        `SCLI_ADDR_CTRL:
        begin
          s_nxt.rdata = 32'(s_r.ind_en);
          if (wb_we_in && wb_sel_in[0])
          begin
            s_nxt.ind_en = wb_dat_in[0];
          end
        end
        `SCLI_ADDR_STATUS:
        begin
          s_nxt.rdata = 32'({s_r.captured, collision_in, full_duplex_in,
            speed100_in, link_up_in});
        end
        default:
        begin
          s_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_r <= ST_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // all outputs straight from the state flops
  assign wb_dat_out = s_r.rdata;
  assign wb_ack_out = s_r.ack;
  assign port_indicator_zero_out = s_r.led0;
  assign port_indicator_one_out = s_r.led1;
  assign port_indicator_two_out = s_r.led2;
  assign port_indicator_three_out = s_r.led3;
  assign port_indicator_oe_b_out = s_r.oe_b;
  assign ext_collision_fwd_out = s_r.col_fwd;
  assign led_mode_out = s_r.led_mode;
  assign factory_test_out = s_r.factory_test;
  assign max_len_untag_out = s_r.len_untag;
  assign max_len_tag_out = s_r.len_tag;
  assign force_pause_out = s_r.force_pause;
  assign advertise_pause_out = s_r.advertise;
  assign aging_on_out = s_r.aging;
  assign force_speed100_out = s_r.fspd;
  assign p3_autoneg_off_out = s_r.an3_off;
  assign ext_port_mode_out = s_r.ext_mode;

  // checks
  property p_mode_frozen;
    @(posedge clock_in) disable iff (!rst_b_in)
    $past(s_r.captured) |-> $stable(led_mode_out) && $stable(s_r.code);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen)
    else $error("led mode changed after capture");

  property p_long_code;
    @(posedge clock_in) disable iff (!rst_b_in)
    $rose(s_r.captured) && s_r.code == 4'hb |->
      led_mode_out == 2'h3 && max_len_tag_out == 11'h600 && !factory_test_out;
  endproperty
  a_long_code: assert property (p_long_code)
    else $error("code 1011 decoded wrongly");

  property p_speed_lamp;
    @(posedge clock_in) disable iff (!rst_b_in)
    s_r.captured && s_r.ind_en && led_mode_out == 2'h0 && speed100_in[0]
      |=> port_indicator_zero_out[0] == 1'b0;
  endproperty
  a_speed_lamp: assert property (p_speed_lamp)
    else $error("speed lamp not lit at 100M");

  property p_duplex_lamp;
    @(posedge clock_in) disable iff (!rst_b_in)
    s_r.captured && s_r.ind_en && led_mode_out != 2'h3
      |=> port_indicator_one_out[1] == !$past(full_duplex_in[1]);
  endproperty
  a_duplex_lamp: assert property (p_duplex_lamp)
    else $error("duplex lamp wrong");

  property p_pause_p1;
    @(posedge clock_in) disable iff (!rst_b_in)
    $rose(s_r.captured) |-> force_pause_out[0] == !$past(force_pause_p1_n_in)
      && advertise_pause_out == $past(port_indicator_three_in[0]);
  endproperty
  a_pause_p1: assert property (p_pause_p1)
    else $error("pause strap capture wrong");

  property p_aging;
    @(posedge clock_in) disable iff (!rst_b_in)
    $rose(s_r.captured) |-> aging_on_out == $past(port_indicator_three_in[1]);
  endproperty
  a_aging: assert property (p_aging)
    else $error("aging strap capture wrong");

  property p_fspd;
    @(posedge clock_in) disable iff (!rst_b_in)
    $rose(s_r.captured) |->
      force_speed100_out[2] == $past(port_indicator_two_in[2]) &&
      force_speed100_out[0] == $past(port_indicator_zero_in[2]);
  endproperty
  a_fspd: assert property (p_fspd)
    else $error("forced speed strap capture wrong");

  property p_fwd_col;
    @(posedge clock_in) disable iff (!rst_b_in)
    ext_port_mode_out != SCLI_EXT_FORWARD |=> !ext_collision_fwd_out;
  endproperty
  a_fwd_col: assert property (p_fwd_col)
    else $error("collision passed outside forward mode");

  property p_oe_hold;
    @(posedge clock_in) disable iff (!rst_b_in)
    !s_r.captured |=> port_indicator_oe_b_out == 3'h7;
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("indicator driven before capture");

endmodule
`default_nettype wire

// file: test_strap_config_led_indicators.sv
`timescale 1ns/100ps
`default_nettype none
module test_strap_config_led_indicators
  import scli_pkg::*;
;
  localparam int BLINK = 4;
  // bus and straps
  logic clock_in, rst_b_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [3:0] wb_adr_in, wb_sel_in, indicator_mode_select_in;
  logic [31:0] wb_dat_in, wb_dat_out;
  logic force_pause_p1_n_in, force_pause_p2_n_in, p3_autoneg_off_in;
  logic [1:0] ext_port_mode_sel_in, led_mode_out;
  logic [11:0] strap, lamp, lo, hi;
  wire logic [11:0] pin_lvl;
  // pins and status
  wire logic [2:0] port_indicator_zero_in, port_indicator_one_in;
  wire logic [2:0] port_indicator_two_in, port_indicator_three_in;
  logic [2:0] port_indicator_zero_out, port_indicator_one_out;
  logic [2:0] port_indicator_two_out, port_indicator_three_out;
  logic [2:0] port_indicator_oe_b_out, link_up_in, speed100_in;
  logic [2:0] full_duplex_in, rx_active_in, tx_active_in, collision_in;
  logic ext_collision_in, ext_collision_fwd_out, factory_test_out;
  logic advertise_pause_out, aging_on_out, p3_autoneg_off_out;
  logic [10:0] max_len_untag_out, max_len_tag_out;
  logic [2:0] force_pause_out, force_speed100_out;
  scli_ext_mode_t ext_port_mode_out;
  logic [31:0] exp_q[$];
  int n_mismatch, checked;

  assign lamp = {port_indicator_three_out, port_indicator_two_out,
    port_indicator_one_out, port_indicator_zero_out};
  assign {port_indicator_three_in, port_indicator_two_in,
    port_indicator_one_in, port_indicator_zero_in} = pin_lvl;

  scli_board i_board (.strap_in(strap), .drv_in(lamp),
    .oe_b_in(port_indicator_oe_b_out), .lvl_out(pin_lvl));
  scli_top #(.BLINK_CYCLES(BLINK)) i_dut (.clock_in, .rst_b_in, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out,
    .wb_ack_out, .indicator_mode_select_in, .force_pause_p1_n_in,
    .force_pause_p2_n_in, .p3_autoneg_off_in, .ext_port_mode_sel_in,
    .port_indicator_zero_in, .port_indicator_one_in, .port_indicator_two_in,
    .port_indicator_three_in, .port_indicator_zero_out,
    .port_indicator_one_out, .port_indicator_two_out,
    .port_indicator_three_out, .port_indicator_oe_b_out, .link_up_in,
    .speed100_in, .full_duplex_in, .rx_active_in, .tx_active_in,
    .collision_in, .ext_collision_in, .ext_collision_fwd_out, .led_mode_out,
    .factory_test_out, .max_len_untag_out, .max_len_tag_out,
    .force_pause_out, .advertise_pause_out, .aging_on_out,
    .force_speed100_out, .p3_autoneg_off_out, .ext_port_mode_out);

  // free running core clock
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one classic cycle; read expectations go to the queue
  task automatic wb(input logic we, input logic [3:0] adr, sel,
    input logic [31:0] dat, e);
    @(posedge clock_in);
    {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'h3, we};
    {wb_adr_in, wb_sel_in, wb_dat_in} <= {adr, sel, dat};
    if (!we)
      exp_q.push_back(e);
    // no latency assumed; a missing ack is left to the watchdog
    @(posedge clock_in);
    while (wb_ack_out !== 1'b1)
      @(posedge clock_in);
    {wb_cyc_in, wb_stb_in, wb_we_in} <= 3'h0;
  endtask

  // reset is level; straps stay put until the capture edge
  task automatic do_reset;
    rst_b_in <= 1'b0;
    repeat (20) @(posedge clock_in);
    chk("oe_b_reset", port_indicator_oe_b_out, 3'h7);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    chk("oe_b_run", port_indicator_oe_b_out, 3'h0);
  endtask

  // {long frames, factory test, led mode} per mode code
  function automatic logic [3:0] code_dec(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3: return {2'h0, c[1:0]};
      4'hb: return 4'hb;
      4'hc: return 4'h8;
      4'he: return 4'ha;
      default: return 4'h4;
    endcase
  endfunction

  // steady lamp levels, low = lit, no traffic
  function automatic logic [11:0] led_exp(input logic [1:0] m,
    input logic [2:0] l, s, f);
    logic [2:0] i0, i1, i2, i3;
    i0 = (m == 2'h0 || m == 2'h3) ? ~s : 3'h7;
    i1 = (m == 2'h3) ? 3'h7 : ~f;
    i2 = (m == 2'h2) ? ~(l & ~s) : (m == 2'h3) ? ~(l & f) : 3'h7;
    i3 = (m == 2'h1) ? 3'h7 : (m == 2'h2) ? ~(l & s) : ~l;
    return {i3, i2, i1, i0};
  endfunction

  // read data is judged at the edge where ack is sampled
  always @(posedge clock_in)
    if (wb_ack_out === 1'b1 && wb_we_in === 1'b0 && exp_q.size() > 0)
      chk("wb_rdata", wb_dat_out, exp_q.pop_front());

  // hang guard, far beyond the thousand or so cycles needed
  initial
  begin
    repeat (20000) @(posedge clock_in);
    n_mismatch++;
    summarize;
  end

  initial
  begin
    logic [31:0] r;
    logic [3:0] d;
    n_mismatch = 0;
    checked = 0;
    {rst_b_in, wb_cyc_in, wb_stb_in, wb_we_in, ext_collision_in} = '0;
    {wb_adr_in, wb_sel_in, wb_dat_in, strap} = '0;
    {indicator_mode_select_in, ext_port_mode_sel_in} = '0;
    {force_pause_p1_n_in, force_pause_p2_n_in, p3_autoneg_off_in} = '1;
    {link_up_in, speed100_in, full_duplex_in} = '0;
    {rx_active_in, tx_active_in, collision_in} = '0;
    void'($urandom(32'h0000_076b));
    // every mode code with random straps, wandering after capture
    for (int c = 0; c < 16; c++)
    begin
      r = $urandom;
      d = code_dec(4'(c));
      indicator_mode_select_in <= 4'(c);
      {ext_port_mode_sel_in, p3_autoneg_off_in} <= r[2:0];
      {strap, force_pause_p2_n_in, force_pause_p1_n_in} <= r[16:3];
      do_reset;
      indicator_mode_select_in <= ~indicator_mode_select_in;
      {strap, force_pause_p2_n_in, force_pause_p1_n_in} <= ~r[16:3];
      {ext_port_mode_sel_in, p3_autoneg_off_in} <= ~r[2:0];
      ext_collision_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      chk("mode", {factory_test_out, led_mode_out}, d[2:0]);
      if (!d[2])
        chk("len", {max_len_untag_out, max_len_tag_out}, d[3] ?
          {11'h600, 11'h600} : {11'h5ee, 11'h5f2});
      chk("pause", {advertise_pause_out, force_pause_out},
        {r[14], r[11], ~r[4:3]});
      chk("aging", aging_on_out, r[15]);
      chk("speed", force_speed100_out, {r[13], r[10], r[7]});
      chk("an_ext", {p3_autoneg_off_out, ext_port_mode_out},
        {r[0], r[2:1]});
      chk("ext_col", ext_collision_fwd_out, r[2:1] == 2'h2);
      ext_collision_in <= 1'b0;
      wb(1'b0, 4'h0, 4'hf, 32'h0, {13'h0, 4'(c), r[2:0], r[13], r[10],
        r[7], r[15], r[14], r[11], ~r[4:3], d});
    end
    $display("strap capture test done");
    // steady levels, then blinking and settling, in each led mode
    for (int m = 0; m < 4; m++)
    begin
      indicator_mode_select_in <= 4'(m);
      do_reset;
      for (int t = 0; t < 4; t++)
      begin
        r = $urandom;
        {link_up_in, speed100_in, full_duplex_in} <= r[8:0];
        repeat (12) @(posedge clock_in);
        chk("lamp", lamp, led_exp(2'(m), r[8:6], r[5:3],
          r[2:0]));
        wb(1'b0, 4'h8, 4'hf, 32'h0, {19'h0, 1'b1, 3'h0, r[2:0], r[5:3],
          r[8:6]});
      end
      {link_up_in, speed100_in, full_duplex_in} <= {6'h3f, 3'h0};
      {rx_active_in, tx_active_in, collision_in} <= '1;
      repeat (4) @(posedge clock_in);
      {lo, hi} = '0;
      repeat (24)
      begin
        @(posedge clock_in);
        lo = lo | ~lamp;
        hi = hi | lamp;
      end
      chk("blink", lo & hi, (m == 2) ? 12'he07 :
        12'hfc0);
      {rx_active_in, tx_active_in, collision_in} <= '0;
      repeat (12) @(posedge clock_in);
      chk("settle", lamp, led_exp(2'(m), 3'h7, 3'h7, 3'h0));
      $display("led mode %0d test done", m);
    end
    // enable register, ignored writes and an unmapped place
    wb(1'b0, 4'h4, 4'hf, 32'h0, 32'h1);
    wb(1'b1, 4'h4, 4'h1, 32'h0, 32'h0);
    repeat (4) @(posedge clock_in);
    chk("dark", lamp, 12'hfff);
    wb(1'b1, 4'h4, 4'h0, 32'h1, 32'h0);
    wb(1'b0, 4'h4, 4'hf, 32'h0, 32'h0);
    wb(1'b1, 4'h4, 4'h1, 32'h1, 32'h0);
    wb(1'b0, 4'h4, 4'hf, 32'h0, 32'h1);
    wb(1'b1, 4'hc, 4'hf, 32'hffff_ffff, 32'h0);
    wb(1'b0, 4'hc, 4'hf, 32'h0, 32'h0);
    repeat (4) @(posedge clock_in);
    $display("register test done");
    summarize;
  end
endmodule
`default_nettype wire
